//--- logic/ddf_consts.svh
`ifndef DDF_CONSTS_SVH
`define DDF_CONSTS_SVH

`define DDF_CHANNELS 16
`define DDF_CNT_W 12
`define DDF_CLK_MHZ 25
`define DDF_TICK_US 10
`define DDF_TICK_CYCLES (`DDF_TICK_US * `DDF_CLK_MHZ)

// Longest bounce ignored and shortest level sensed per range, in microseconds.
`define DDF_IGNORE_10HZ_US 20000
`define DDF_IGNORE_100HZ_US 2000
`define DDF_IGNORE_1KHZ_US 200
`define DDF_SENSE_10HZ_US 50000
`define DDF_SENSE_100HZ_US 5000
`define DDF_SENSE_1KHZ_US 1000

// Acceptance time sits between the two limits of each range.
`define DDF_ACCEPT_10HZ_US ((`DDF_IGNORE_10HZ_US + `DDF_SENSE_10HZ_US * 0) * 5 / 4)
`define DDF_ACCEPT_100HZ_US ((`DDF_IGNORE_100HZ_US + `DDF_SENSE_100HZ_US * 0) * 5 / 4)
`define DDF_ACCEPT_1KHZ_US ((`DDF_IGNORE_1KHZ_US + `DDF_SENSE_1KHZ_US * 0) * 5 / 2)
`define DDF_ACCEPT_10HZ_TICKS (`DDF_ACCEPT_10HZ_US / `DDF_TICK_US)
`define DDF_ACCEPT_100HZ_TICKS (`DDF_ACCEPT_100HZ_US / `DDF_TICK_US)
`define DDF_ACCEPT_1KHZ_TICKS (`DDF_ACCEPT_1KHZ_US / `DDF_TICK_US)

`endif

//--- logic/ddf_pkg.sv
package ddf_pkg;
  typedef enum logic [1:0] {
    DDF_RANGE_10HZ = 2'h0,
    DDF_RANGE_100HZ = 2'h1,
    DDF_RANGE_1KHZ = 2'h2,
    DDF_RANGE_SPARE = 2'h3
  } ddf_range_type;
endpackage

//--- logic/ddf_ctl_if.sv
`timescale 1ns/10ps
`include "ddf_consts.svh"

interface ddf_ctl_if;
  logic tick;
  logic [`DDF_CNT_W-1:0] limit;
  modport source (output tick, output limit);
  modport sink (input tick, input limit);
endinterface

//--- logic/ddf_channel.sv
`timescale 1ns/10ps
`include "ddf_consts.svh"

module ddf_channel (
  input wire logic ref_clk,
  input wire logic rst_n,
  ddf_ctl_if.sink ctl,
  input wire logic field_in,
  output logic chan_level,
  output logic rise_evt,
  output logic fall_evt
);
  logic sync_a;
  logic sync_b;
  logic [`DDF_CNT_W-1:0] cnt;
  wire differs;
  wire accept;
  wire [`DDF_CNT_W-1:0] cnt_inc;

  assign differs = sync_b != chan_level;
  assign cnt_inc = cnt + 12'h001;
  assign accept = differs && ctl.tick && (cnt_inc >= ctl.limit);

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
    end else begin
      sync_a <= field_in;
      sync_b <= sync_a;
    end
  end

  // Any return to the held level restarts the count, so the longest high
  // excursion of a bounce burst is what must stay under the limit.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cnt <= 12'h000;
    end else if (!differs || accept) begin
      cnt <= 12'h000;
    end else if (ctl.tick) begin
      cnt <= cnt_inc;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      chan_level <= 1'b0;
      rise_evt <= 1'b0;
      fall_evt <= 1'b0;
    end else begin
      if (accept) begin
        chan_level <= sync_b;
      end
      rise_evt <= accept && sync_b;
      fall_evt <= accept && !sync_b;
    end
  end

  a_level_needs_count: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $changed(chan_level) |-> $past(ctl.tick) && ($past(cnt) + 12'h001 >= $past(ctl.limit)))
    else $error("level changed before the stable count was reached");
  a_reversal_restarts: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (sync_b == chan_level) |=> (cnt == 12'h000))
    else $error("count kept running after the input returned");
  a_rise_marks_edge: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(chan_level) |-> rise_evt && !fall_evt)
    else $error("rising level without a rise event");
  a_fall_marks_edge: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $fell(chan_level) |-> fall_evt && !rise_evt)
    else $error("falling level without a fall event");
  a_edge_one_cycle: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (rise_evt || fall_evt) |=> !rise_evt && !fall_evt)
    else $error("edge event held longer than one cycle");
  a_count_follows_tick: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (differs && !ctl.tick) |=> (cnt == $past(cnt)))
    else $error("count moved without a sample tick");
endmodule

//--- logic/ddf_filter.sv
`timescale 1ns/10ps
`include "ddf_consts.svh"

// Operation
// - One shared range setting sets the filter time of all sixteen channels.
// - Excursions up to 20, 2 or 0.2 ms are ignored per range.
// - Levels lasting 50, 5 or 1 ms are always sensed per range.
// - Inputs changing up to 10, 100 or 500 Hz are tracked.
// - Pulses between the ignore and sense limits may pass or be dropped.
// - A pulse under the ignore limit never changes the filtered level.
// - Bounce longer than the ignore limit may register as real changes.
// - Bounce length is the longest high interval; that interval is rejected.
// - Edge to event delay differs for each of the three ranges.
// - Each channel shows its filtered level, 0 low and 1 high, continuously.
module ddf_filter #(
  parameter logic [`DDF_CNT_W-1:0] ACCEPT_10HZ_TICKS = `DDF_CNT_W'(`DDF_ACCEPT_10HZ_TICKS),
  parameter logic [`DDF_CNT_W-1:0] ACCEPT_100HZ_TICKS = `DDF_CNT_W'(`DDF_ACCEPT_100HZ_TICKS),
  parameter logic [`DDF_CNT_W-1:0] ACCEPT_1KHZ_TICKS = `DDF_CNT_W'(`DDF_ACCEPT_1KHZ_TICKS)
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [1:0] debounce_range_select,
  input wire logic [`DDF_CHANNELS-1:0] field_in,
  output logic [`DDF_CHANNELS-1:0] chan_level,
  output logic [`DDF_CHANNELS-1:0] rise_evt,
  output logic [`DDF_CHANNELS-1:0] fall_evt
);
  localparam logic [7:0] TICK_LAST = 8'(`DDF_TICK_CYCLES - 1);

  ddf_ctl_if ctl ();

  logic [1:0] range_a;
  ddf_pkg::ddf_range_type range_q;
  logic [7:0] div;
  logic tick;
  logic [`DDF_CNT_W-1:0] limit;
  wire tick_due;
  wire [`DDF_CNT_W-1:0] next_limit;

  assign tick_due = div == TICK_LAST;

  // An unused jumper code falls back to the slowest, safest range.
  assign next_limit = (range_q == ddf_pkg::DDF_RANGE_1KHZ) ? ACCEPT_1KHZ_TICKS :
                      (range_q == ddf_pkg::DDF_RANGE_100HZ) ? ACCEPT_100HZ_TICKS :
                      ACCEPT_10HZ_TICKS;

  assign ctl.tick = tick;
  assign ctl.limit = limit;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      range_a <= 2'h0;
      range_q <= ddf_pkg::DDF_RANGE_10HZ;
    end else begin
      range_a <= debounce_range_select;
      range_q <= ddf_pkg::ddf_range_type'(range_a);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      div <= 8'h00;
      tick <= 1'b0;
    end else begin
      div <= tick_due ? 8'h00 : div + 8'h01;
      tick <= tick_due;
    end
  end

  // Acceptance sits above the ignore limit and well under the sense width,
  // which leaves room for the sync and tick jitter and for the fastest rate.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      limit <= ACCEPT_10HZ_TICKS;
    end else begin
      limit <= next_limit;
    end
  end

  genvar ch;
  generate
    for (ch = 0; ch < `DDF_CHANNELS; ch++) begin : g_chan
      ddf_channel u_chan (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .ctl(ctl),
        .field_in(field_in[ch]),
        .chan_level(chan_level[ch]),
        .rise_evt(rise_evt[ch]),
        .fall_evt(fall_evt[ch])
      );
    end
  endgenerate

  // Range selection: each used code must land on its own acceptance count, and
  // the spare code on the slow count, one cycle after the synchronised code settles.
  a_range_limit: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (range_q == ddf_pkg::DDF_RANGE_100HZ) |=> (limit == ACCEPT_100HZ_TICKS))
    else $error("100 Hz range did not select its acceptance count");

  a_range_fast: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (range_q == ddf_pkg::DDF_RANGE_1KHZ) |=> (limit == ACCEPT_1KHZ_TICKS))
    else $error("1 kHz range did not select its acceptance count");

  a_range_slow: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (range_q == ddf_pkg::DDF_RANGE_10HZ) |=> (limit == ACCEPT_10HZ_TICKS))
    else $error("10 Hz range did not select its acceptance count");

  a_range_spare: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (range_q == ddf_pkg::DDF_RANGE_SPARE) |=> (limit == ACCEPT_10HZ_TICKS))
    else $error("unused range code did not fall back to the slow count");

  a_limit_known: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (limit == ACCEPT_10HZ_TICKS) || (limit == ACCEPT_100HZ_TICKS) ||
    (limit == ACCEPT_1KHZ_TICKS))
    else $error("acceptance count is none of the three ranges");

  a_limit_nonzero: assert property (@(posedge ref_clk) disable iff (!rst_n)
    limit != 12'h000)
    else $error("acceptance count of zero would pass any glitch");

  a_limit_stable: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $stable(range_q) |=> $stable(limit))
    else $error("acceptance count moved without a range change");

  // The jumper code crosses two flops before it is decoded.
  a_range_stage: assert property (@(posedge ref_clk) disable iff (!rst_n)
    1'b1 |=> (range_a == $past(debounce_range_select)))
    else $error("first range flop did not follow the pin");

  a_range_sync: assert property (@(posedge ref_clk) disable iff (!rst_n)
    1'b1 |=> (range_q == ddf_pkg::ddf_range_type'($past(range_a))))
    else $error("second range flop did not follow the first");

  // Sample tick: one pulse every 250 cycles, which fixes the 10 us grain of
  // every acceptance time.
  a_tick_spacing: assert property (@(posedge ref_clk) disable iff (!rst_n)
    tick |=> !tick [*8])
    else $error("sample ticks closer than expected");

  a_tick_present: assert property (@(posedge ref_clk) disable iff (!rst_n)
    tick |-> ##[1:250] tick)
    else $error("sample tick missing");

  a_tick_period: assert property (@(posedge ref_clk) disable iff (!rst_n)
    tick |-> ##250 tick)
    else $error("sample tick period is not 250 cycles");

  a_tick_from_due: assert property (@(posedge ref_clk) disable iff (!rst_n)
    1'b1 |=> (tick == $past(tick_due)))
    else $error("tick does not follow the divider terminal count");

  a_tick_div_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
    tick |-> (div == 8'h00))
    else $error("tick out of step with the divider wrap");

  a_div_bound: assert property (@(posedge ref_clk) disable iff (!rst_n)
    div <= TICK_LAST)
    else $error("divider ran past its terminal count");

  a_div_wrap: assert property (@(posedge ref_clk) disable iff (!rst_n)
    tick_due |=> (div == 8'h00))
    else $error("divider did not wrap at its terminal count");

  a_div_step: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !tick_due |=> (div == $past(div) + 8'h01))
    else $error("divider skipped a count");

  a_due_once: assert property (@(posedge ref_clk) disable iff (!rst_n)
    tick_due |=> !tick_due)
    else $error("divider terminal count held for two cycles");

  // Top-level view of each channel: the event pins must agree with the
  // level pins, since downstream counters rely on both.
  generate
    for (ch = 0; ch < `DDF_CHANNELS; ch++) begin : g_chk
      a_rise_level: assert property (@(posedge ref_clk) disable iff (!rst_n)
        rise_evt[ch] |-> chan_level[ch] && !$past(chan_level[ch]))
        else $error("rise event without a rising level");

      a_fall_level: assert property (@(posedge ref_clk) disable iff (!rst_n)
        fall_evt[ch] |-> !chan_level[ch] && $past(chan_level[ch]))
        else $error("fall event without a falling level");

      a_no_both: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !(rise_evt[ch] && fall_evt[ch]))
        else $error("rise and fall events in one cycle");

      a_level_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !(rise_evt[ch] || fall_evt[ch]) |-> $stable(chan_level[ch]))
        else $error("level moved without an edge event");

      a_event_on_tick: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (rise_evt[ch] || fall_evt[ch]) |-> $past(tick))
        else $error("edge event not aligned to a sample tick");
    end
  endgenerate
endmodule

//--- test/ddf_field_model.sv
`timescale 1ns/10ps
`include "ddf_consts.svh"

// Stands in for the attenuated field lines, which are always driven logic levels.
module ddf_field_model (
  input wire logic ref_clk,
  output logic [`DDF_CHANNELS-1:0] field_in
);
  initial field_in = 16'h0000;

  // Applies a level just after an edge and holds it for the given number of cycles.
  task automatic drive(input logic [`DDF_CHANNELS-1:0] v, input int hold);
    @(posedge ref_clk);
    field_in <= v;
    repeat (hold) @(posedge ref_clk);
  endtask

  // A bounce train of short highs with brief lows between them.
  task automatic bounce(input logic [`DDF_CHANNELS-1:0] v, input int high, input int low);
    repeat (3) begin
      drive(v, high);
      drive(16'h0000, low);
    end
  endtask
endmodule

//--- test/tb.sv
`timescale 1ns/10ps
`include "ddf_consts.svh"

module tb;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] sel = 2'h0;
  logic [15:0] field_in, lvl, rise, fall, seen;
  logic seen_clr = 1'b1;
  int err_total = 0;
  int checked = 0;
  int cyc = 0;
  int n_tab [4] = '{4, 3, 2, 4};

  always #20 ref_clk = ~ref_clk;
  ddf_field_model i_src (.ref_clk(ref_clk), .field_in(field_in));
  ddf_filter #(.ACCEPT_10HZ_TICKS(12'h004), .ACCEPT_100HZ_TICKS(12'h003),
    .ACCEPT_1KHZ_TICKS(12'h002)) i_dut (.ref_clk(ref_clk), .rst_n(rst_n),
    .debounce_range_select(sel), .field_in(field_in), .chan_level(lvl),
    .rise_evt(rise), .fall_evt(fall));

  task automatic check(input logic ok, input string msg);
    checked++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("mismatch t=%0t %s", $time, msg);
    end
  endtask

  task automatic results;
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Ceiling sits well above the roughly 20000 cycles the tests need.
  always @(posedge ref_clk) begin
    cyc++;
    seen <= seen_clr ? 16'h0000 : (seen | rise | fall);
    if (cyc == 60000) begin
      err_total++;
      results();
    end
  end

  task automatic t_accept(input logic [1:0] s, input int n, input logic [15:0] v);
    int c;
    logic [15:0] old;
    old = lvl;
    @(posedge ref_clk);
    sel <= s;
    repeat (4) @(posedge ref_clk);
    i_src.drive(v, 0);
    c = 0;
    while (lvl !== v && c < n * 250 + 400) begin
      @(posedge ref_clk);
      #1;
      c++;
    end
    check(lvl === v, "level not taken");
    check(c >= (n - 1) * 250 && c <= n * 250 + 260, "accept delay");
    check(rise === (v & ~old) && fall === (old & ~v), "edge events");
    @(posedge ref_clk);
    #1;
    check(rise === 16'h0000 && fall === 16'h0000, "event width");
    $display("accept range %0d done", s);
  endtask

  task automatic t_reject(input logic [1:0] s, input int n);
    @(posedge ref_clk);
    sel <= s;
    repeat (4) @(posedge ref_clk);
    seen_clr <= 1'b1;
    @(posedge ref_clk);
    seen_clr <= 1'b0;
    i_src.bounce(16'h0008, (n - 1) * 250 - 20, 10);
    repeat (n * 250 + 300) @(posedge ref_clk);
    #1;
    check(lvl === 16'h0000 && seen === 16'h0000, "bounce passed");
    $display("reject range %0d done", s);
  endtask

  initial begin
    repeat (16) @(posedge ref_clk);
    #1;
    check(lvl === 16'h0000 && rise === 16'h0000 && fall === 16'h0000, "reset outputs");
    @(posedge ref_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      t_reject(2'(i), n_tab[i]);
      t_accept(2'(i), n_tab[i], 16'hFFFF);
      t_accept(2'(i), n_tab[i], 16'hA5C3);
      t_accept(2'(i), n_tab[i], 16'h0000);
    end
    results();
  end
endmodule
